/* sync_serial_pkg.sv */
// Constants and types for the synchronous serial slave port
package sync_serial_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h04;
    localparam logic [7:0] OFS_IRQ_ENABLES = 8'h08;
    localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h0C;
    localparam logic [7:0] OFS_RX_STATUS = 8'h10;
    localparam logic [7:0] OFS_TX_BUFFER = 8'h14;
    localparam logic [7:0] OFS_TX_STATUS = 8'h18;
    localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h1C;
    localparam logic [7:0] OFS_RX_BUFFER = 8'h20;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int INT_GLOBAL = 7;
    localparam int INT_PERIPH = 6;
    localparam int IRQ_RX = 5;
    localparam int IRQ_TX = 4;
    localparam int TXS_CLOCK_SOURCE = 7;
    localparam int TXS_NINE = 6;
    localparam int TXS_ENABLE = 5;
    localparam int TXS_SYNC = 4;
    localparam int TXS_HIGH_BAUD = 2;
    localparam int TXS_NINTH = 0;
    localparam int RCS_PORT_ENABLE = 7;
    localparam int RCS_NINE = 6;
    localparam int RCS_SINGLE = 5;
    localparam int RCS_CONT = 4;
    localparam int RCS_ADDR_DETECT = 3;

    // ****************************************************************
    // Masks, reset values and word lengths
    // ****************************************************************
    localparam logic [7:0] FLAGS_RW_MASK = 8'hCB;
    localparam logic [7:0] ENABLES_RW_MASK = 8'hFB;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] WORD_LEN_8 = 4'h8;
    localparam logic [3:0] WORD_LEN_9 = 4'h9;

    typedef struct packed {
        logic level;
        logic enable;
    } pin_drive_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] intctl;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] priority_bits;
        logic [7:0] divisor;
        logic clock_source_select;
        logic tx9;
        logic transmit_enable;
        logic sync_mode;
        logic high_baud_select;
        logic transmit_ninth_bit;
        logic serial_port_enable;
        logic rx9;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
        logic overrun_error;
        logic received_ninth_bit;
        logic [7:0] txbuf;
        logic txbuf9;
        logic full;
        logic [8:0] transmit_shift_register;
        logic [3:0] tcnt;
        logic busy;
        logic [8:0] receive_shift_register;
        logic [3:0] rcnt;
        logic [7:0] rcbuf;
        logic receive_complete_flag;
        logic transmit_buffer_empty_flag;
        logic ck_s1;
        logic ck_s2;
        logic ck_prev;
        logic dt_s1;
        logic dt_s2;
    } state_type;

endpackage : sync_serial_pkg

/* sync_serial_slave_port.sv */
// Synchronous serial slave port with classic Wishbone register access
`timescale 1ns/1ns

module sync_serial_slave_port
    import sync_serial_pkg::*;
(
    input wire logic mclk,                     // System clock, 20 MHz
    input wire logic rst_n,                    // Synchronous reset, active low
    input wire logic wb_cyc_i,                 // Wishbone cycle
    input wire logic wb_stb_i,                 // Wishbone strobe
    input wire logic wb_we_i,                  // Wishbone write enable
    input wire logic [7:0] wb_adr_i,           // Wishbone byte address
    input wire logic [3:0] wb_sel_i,           // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,          // Wishbone write data
    output logic [31:0] wb_dat_o,              // Wishbone read data
    output logic wb_ack_o,                     // Wishbone acknowledge
    input wire logic serial_clock_pin,         // Shift clock from the master
    input wire logic serial_data_in,           // Data pin level
    output pin_drive_type serial_data_drive,   // Data pin drive and enable
    output logic irq_request,                  // Interrupt to the vector logic
    output logic wake_request                  // Wake from sleep
);

    // ****************************************************************
    // State and derived terms
    // ****************************************************************
    state_type state_reg;
    state_type state_next;

    logic access;
    logic fire;
    logic wr;
    logic rd;
    logic slave_mode;
    logic tx_ok;
    logic rx_ok;
    logic fall;
    logic tx_load;
    logic tx_last;
    logic rx_done;
    logic [3:0] rx_len;
    logic [8:0] rx_shift;
    logic [7:0] rx_byte;

    assign access = wb_cyc_i & wb_stb_i;
    // Write and read side effects happen on the edge that completes the cycle
    assign fire = access & state_reg.ack;
    assign wr = fire & wb_we_i & wb_sel_i[0];
    assign rd = fire & ~wb_we_i;

    assign slave_mode = state_reg.sync_mode & state_reg.serial_port_enable & ~state_reg.clock_source_select;
    assign tx_ok = slave_mode & state_reg.transmit_enable;
    // Single receive plays no part here
    assign rx_ok = slave_mode & state_reg.continuous_receive_enable & ~state_reg.overrun_error
                   & ~(tx_ok & state_reg.busy);
    assign fall = state_reg.ck_prev & ~state_reg.ck_s2;
    assign tx_last = fall & state_reg.busy & (state_reg.tcnt == 4'h1);
    assign tx_load = tx_ok & state_reg.full & (~state_reg.busy | tx_last);
    assign rx_len = state_reg.rx9 ? WORD_LEN_9 : WORD_LEN_8;
    assign rx_done = rx_ok & fall & (state_reg.rcnt == rx_len - 4'h1);
    // Bits enter at the top, so an eight-bit word ends up one place high
    assign rx_shift = {state_reg.dt_s2, state_reg.receive_shift_register[8:1]};
    assign rx_byte = state_reg.rx9 ? rx_shift[7:0] : rx_shift[8:1];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.ck_s1 = serial_clock_pin;
        state_next.ck_s2 = state_reg.ck_s1;
        state_next.ck_prev = state_reg.ck_s2;
        state_next.dt_s1 = serial_data_in;
        state_next.dt_s2 = state_reg.dt_s1;
        state_next.ack = access & ~state_reg.ack;

        if (access & ~state_reg.ack)
        begin
            case (wb_adr_i)
                OFS_INTERRUPT_CONTROL: state_next.rdata = {24'h0, state_reg.intctl};
                OFS_IRQ_FLAGS: state_next.rdata = {24'h0, state_reg.flags[7:6],
                    state_reg.receive_complete_flag, state_reg.transmit_buffer_empty_flag, state_reg.flags[3:0]};
                OFS_IRQ_ENABLES: state_next.rdata = {24'h0, state_reg.enables};
                OFS_IRQ_PRIORITY: state_next.rdata = {24'h0, state_reg.priority_bits};
                OFS_RX_STATUS: state_next.rdata = {24'h0, state_reg.serial_port_enable, state_reg.rx9,
                    state_reg.single_receive_enable, state_reg.continuous_receive_enable, state_reg.address_detect_enable, 1'b0,
                    state_reg.overrun_error, state_reg.received_ninth_bit};
                OFS_TX_BUFFER: state_next.rdata = {24'h0, state_reg.txbuf};
                OFS_TX_STATUS: state_next.rdata = {24'h0, state_reg.clock_source_select, state_reg.tx9,
                    state_reg.transmit_enable, state_reg.sync_mode, 1'b0, state_reg.high_baud_select,
                    ~state_reg.busy, state_reg.transmit_ninth_bit};
                OFS_BAUD_DIVISOR: state_next.rdata = {24'h0, state_reg.divisor};
                OFS_RX_BUFFER: state_next.rdata = {24'h0, state_reg.rcbuf};
                default: state_next.rdata = 32'h0;
            endcase
        end

        if (wr)
        begin
            case (wb_adr_i)
                OFS_INTERRUPT_CONTROL: state_next.intctl = wb_dat_i[7:0];
                OFS_IRQ_FLAGS: state_next.flags = wb_dat_i[7:0] & FLAGS_RW_MASK;
                OFS_IRQ_ENABLES: state_next.enables = wb_dat_i[7:0] & ENABLES_RW_MASK;
                OFS_IRQ_PRIORITY: state_next.priority_bits = wb_dat_i[7:0] & ENABLES_RW_MASK;
                OFS_BAUD_DIVISOR: state_next.divisor = wb_dat_i[7:0];
                OFS_RX_STATUS:
                begin
                    state_next.serial_port_enable = wb_dat_i[RCS_PORT_ENABLE];
                    state_next.rx9 = wb_dat_i[RCS_NINE];
                    state_next.single_receive_enable = wb_dat_i[RCS_SINGLE];
                    state_next.continuous_receive_enable = wb_dat_i[RCS_CONT];
                    state_next.address_detect_enable = wb_dat_i[RCS_ADDR_DETECT];
                end
                OFS_TX_STATUS:
                begin
                    state_next.clock_source_select = wb_dat_i[TXS_CLOCK_SOURCE];
                    state_next.tx9 = wb_dat_i[TXS_NINE];
                    state_next.transmit_enable = wb_dat_i[TXS_ENABLE];
                    state_next.sync_mode = wb_dat_i[TXS_SYNC];
                    state_next.high_baud_select = wb_dat_i[TXS_HIGH_BAUD];
                    state_next.transmit_ninth_bit = wb_dat_i[TXS_NINTH];
                end
                default:
                begin
                end
            endcase
        end

        // ************************************************************
        // Transmit shifter, advances on the master's falling edge
        // ************************************************************
        if (fall & state_reg.busy)
        begin
            state_next.transmit_shift_register = {1'b0, state_reg.transmit_shift_register[8:1]};
            state_next.tcnt = state_reg.tcnt - 4'h1;
            if (tx_last)
            begin
                state_next.busy = 1'b0;
            end
        end
        if (tx_load)
        begin
            state_next.transmit_shift_register = {state_reg.txbuf9, state_reg.txbuf};
            state_next.tcnt = state_reg.tx9 ? WORD_LEN_9 : WORD_LEN_8;
            state_next.busy = 1'b1;
            state_next.full = 1'b0;
        end
        // Flag is set on an empty buffer only while transmit is enabled in slave mode
        if (tx_ok & (~state_reg.full | tx_load))
        begin
            state_next.transmit_buffer_empty_flag = 1'b1;
        end
        // A write refills the buffer, so its clear outranks the set
        if (wr & (wb_adr_i == OFS_TX_BUFFER))
        begin
            state_next.txbuf = wb_dat_i[7:0];
            state_next.txbuf9 = state_reg.transmit_ninth_bit;
            state_next.full = 1'b1;
            state_next.transmit_buffer_empty_flag = 1'b0;
        end

        // ************************************************************
        // Receive shifter
        // ************************************************************
        if (rd & (wb_adr_i == OFS_RX_BUFFER))
        begin
            state_next.receive_complete_flag = 1'b0;
        end
        if (rx_ok & fall)
        begin
            state_next.receive_shift_register = rx_shift;
            state_next.rcnt = state_reg.rcnt + 4'h1;
        end
        if (rx_done)
        begin
            state_next.rcnt = 4'h0;
            // Unread buffer: keep old word and flag the overrun
            if (state_reg.receive_complete_flag & ~(rd & (wb_adr_i == OFS_RX_BUFFER)))
            begin
                state_next.overrun_error = 1'b1;
            end
            else
            begin
                state_next.rcbuf = rx_byte;
                state_next.received_ninth_bit = rx_shift[8];
                state_next.receive_complete_flag = 1'b1;
            end
        end
        if (~state_next.continuous_receive_enable | ~slave_mode)
        begin
            state_next.rcnt = 4'h0;
        end
        if (~state_next.continuous_receive_enable)
        begin
            state_next.overrun_error = 1'b0;
        end
        if (~tx_ok)
        begin
            state_next.busy = 1'b0;
            state_next.tcnt = 4'h0;
        end

        if (!rst_n)
        begin
            state_next = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        state_reg <= state_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic tx_pending;
    logic rx_pending;

    assign tx_pending = state_reg.transmit_buffer_empty_flag & state_reg.enables[IRQ_TX];
    assign rx_pending = state_reg.receive_complete_flag & state_reg.enables[IRQ_RX];
    // Wake does not need global enable; vectoring does
    assign wake_request = tx_pending | rx_pending;
    assign irq_request = wake_request & state_reg.intctl[INT_GLOBAL]
                         & state_reg.intctl[INT_PERIPH];
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdata;
    assign serial_data_drive.level = state_reg.transmit_shift_register[0];
    // Receive must be off while sending, else the pin is released
    assign serial_data_drive.enable = tx_ok & state_reg.busy & ~state_reg.continuous_receive_enable;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_last_bit;
        tx_last && state_reg.full && tx_ok;
    endsequence

    sequence seq_refilled;
        state_reg.busy && state_reg.transmit_buffer_empty_flag && !state_reg.full;
    endsequence

    a_tx_load_now: assert property (tx_ok && !state_reg.busy && state_reg.full
        |=> seq_refilled) else $error("buffered word not moved");
    a_transmit_buffer_empty_flag_held: assert property (state_reg.full |-> !state_reg.transmit_buffer_empty_flag)
        else $error("empty flag set while buffer full");
    a_tx_refill_next: assert property (seq_last_bit |=> seq_refilled
        ##0 (state_reg.transmit_shift_register == {$past(state_reg.txbuf9), $past(state_reg.txbuf)}))
        else $error("waiting word not reloaded");
    a_wake_vector: assert property (wake_request && !state_reg.intctl[INT_GLOBAL]
        |-> !irq_request) else $error("vector without global enable");
    a_wake_tx: assert property (state_reg.transmit_buffer_empty_flag && state_reg.enables[IRQ_TX]
        |-> wake_request) else $error("transmit wake missing");
    a_mode_drive: assert property (!slave_mode |-> !serial_data_drive.enable)
        else $error("pin driven outside slave mode");
    a_nine_bit_load: assert property (tx_load && state_reg.tx9
        |=> state_reg.tcnt == WORD_LEN_9 && state_reg.transmit_shift_register[8] == $past(state_reg.txbuf9))
        else $error("ninth bit not loaded");
    a_single_ignored: assert property (!state_reg.continuous_receive_enable |-> state_reg.rcnt == 4'h0)
        else $error("receive ran without continuous enable");
    a_rx_complete: assert property (rx_done && !state_reg.receive_complete_flag
        |=> state_reg.receive_complete_flag && state_reg.rcbuf == $past(rx_byte))
        else $error("received word not buffered");
    a_err_clear: assert property (!state_reg.continuous_receive_enable |-> !state_reg.overrun_error)
        else $error("overrun kept with receive off");
    a_lsb_first: assert property (fall && state_reg.busy && !tx_last && tx_ok
        |=> state_reg.transmit_shift_register == ($past(state_reg.transmit_shift_register) >> 1))
        else $error("shift order wrong");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

endmodule : sync_serial_slave_port

/* serial_master_model.sv */
// Behavioural external master that clocks the slave port's serial link
`timescale 1ns/1ns

module serial_master_model
(
    output logic ck,          // Shift clock towards the device
    output logic dt,          // Master's drive of the data wire
    input wire logic line     // Resolved data wire level
);
    logic last;

    initial
    begin
        ck = 1'b0;
        dt = 1'b0;
        last = 1'b0;
    end

    // ****************************************************************
    // One frame: rise then fall per bit, LSB first
    // ****************************************************************
    // Clock idles low so the first rising edge can sample bit 0 before the
    // first fall shifts it away; when not sending, the wire toggles every bit
    task automatic frame(input int n, input logic send_on, input logic [8:0] send,
                         output logic [8:0] got);
        got = '0;
        #13;
        for (int i = 0; i < n; i++)
        begin
            #200;
            dt = send_on ? send[i] : ~dt;
            last = dt;
            ck = 1'b1;
            #100;
            got[i] = line;
            #100;
            ck = 1'b0;
        end
        #200;
        dt = ~last;
    endtask : frame

endmodule : serial_master_model

/* test_sync_serial_slave_port.sv */
// Self-checking bench for the synchronous serial slave port
`timescale 1ns/1ns

module test_sync_serial_slave_port
    import sync_serial_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic ck;
    logic dt;
    logic line;
    pin_drive_type drive;
    logic irq;
    logic wake;
    logic [8:0] got;
    logic [7:0] q;
    int miscompares = 0;
    int n_checks = 0;
    logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};

    always #25 mclk = ~mclk;

    // Wire resolution: device wins while it drives the data pin
    assign line = drive.enable ? drive.level : dt;

    sync_serial_slave_port i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .serial_clock_pin(ck), .serial_data_in(line),
        .serial_data_drive(drive), .irq_request(irq), .wake_request(wake));

    serial_master_model i_master (.ck(ck), .dt(dt), .line(line));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h000000, d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            miscompares++;
            $display("wrong value ack expected 1 seen timeout");
            close_out();
        end
        #1;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        check($sformatf("reg %h", a), {8'h00, q & m}, {8'h00, exp});
    endtask : rd

    task automatic note(input string name);
        $display("test %s done", name);
    endtask : note

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++)
            rd(ra[i], 8'hFF, (ra[i] == OFS_TX_STATUS) ? 8'h02 : 8'h00);
        note("reset values");
        wr(OFS_RX_STATUS, 8'h80);
        wr(OFS_TX_STATUS, 8'h30);
        rd(OFS_IRQ_FLAGS, 8'h10, 8'h10);
        wr(OFS_IRQ_FLAGS, 8'h00);
        rd(OFS_IRQ_FLAGS, 8'h10, 8'h10);
        wr(OFS_IRQ_ENABLES, 8'h10);
        check("wake", {15'h0, wake}, 16'h1);
        check("irq", {15'h0, irq}, 16'h0);
        wr(OFS_INTERRUPT_CONTROL, 8'hC0);
        check("irq", {15'h0, irq}, 16'h1);
        wr(OFS_TX_BUFFER, 8'hA5);
        wr(OFS_TX_BUFFER, 8'h3C);
        rd(OFS_IRQ_FLAGS, 8'h10, 8'h00);
        check("wake", {15'h0, wake}, 16'h0);
        rd(OFS_TX_STATUS, 8'h02, 8'h00);
        i_master.frame(8, 1'b0, 9'h000, got);
        check("tx word", {7'h0, got}, 16'h00A5);
        rd(OFS_IRQ_FLAGS, 8'h10, 8'h10);
        check("irq", {15'h0, irq}, 16'h1);
        i_master.frame(8, 1'b0, 9'h000, got);
        check("tx word", {7'h0, got}, 16'h003C);
        rd(OFS_TX_STATUS, 8'h02, 8'h02);
        check("drive", {15'h0, drive.enable}, 16'h0);
        note("buffered transmit");
        wr(OFS_TX_STATUS, 8'h71);
        wr(OFS_TX_BUFFER, 8'h0F);
        i_master.frame(9, 1'b0, 9'h000, got);
        check("tx nine", {7'h0, got}, 16'h010F);
        note("nine-bit transmit");
        wr(OFS_TX_STATUS, 8'h10);
        wr(OFS_IRQ_ENABLES, 8'h20);
        wr(OFS_RX_STATUS, 8'hA0);
        i_master.frame(8, 1'b1, 9'h055, got);
        rd(OFS_IRQ_FLAGS, 8'h20, 8'h00);
        check("wake", {15'h0, wake}, 16'h0);
        wr(OFS_RX_STATUS, 8'h90);
        i_master.frame(8, 1'b1, 9'h0C3, got);
        rd(OFS_IRQ_FLAGS, 8'h20, 8'h20);
        check("wake", {15'h0, wake}, 16'h1);
        rd(OFS_RX_BUFFER, 8'hFF, 8'hC3);
        rd(OFS_IRQ_FLAGS, 8'h20, 8'h00);
        wr(OFS_RX_STATUS, 8'hD0);
        i_master.frame(9, 1'b1, 9'h1A5, got);
        rd(OFS_RX_STATUS, 8'h07, 8'h01);
        rd(OFS_RX_BUFFER, 8'hFF, 8'hA5);
        note("receive");
        i_master.frame(9, 1'b1, 9'h012, got);
        i_master.frame(9, 1'b1, 9'h034, got);
        rd(OFS_RX_STATUS, 8'h02, 8'h02);
        rd(OFS_RX_BUFFER, 8'hFF, 8'h12);
        wr(OFS_RX_STATUS, 8'hC0);
        rd(OFS_RX_STATUS, 8'h02, 8'h00);
        note("overrun");
        wr(OFS_RX_STATUS, 8'h90);
        wr(OFS_TX_STATUS, 8'h90);
        i_master.frame(8, 1'b1, 9'h077, got);
        rd(OFS_IRQ_FLAGS, 8'h20, 8'h00);
        wr(OFS_TX_STATUS, 8'h10);
        wr(OFS_RX_STATUS, 8'h80);
        wr(OFS_TX_BUFFER, 8'h99);
        repeat (4) @(posedge mclk);
        check("drive", {15'h0, drive.enable}, 16'h0);
        rd(OFS_TX_STATUS, 8'h02, 8'h02);
        note("mode gating");
        close_out();
    end

endmodule : test_sync_serial_slave_port
